// ===== npc_consts.svh
`ifndef NPC_CONSTS_SVH
`define NPC_CONSTS_SVH

// register offsets (byte addresses, dword aligned)
`define NPC_OFF_WIN2        8'h18
`define NPC_OFF_WIN3        8'h1c
`define NPC_OFF_WIN4        8'h20
`define NPC_OFF_WIN5        8'h24
`define NPC_OFF_SUBSYS      8'h2c
`define NPC_OFF_CAPPTR      8'h34
`define NPC_OFF_IRQ         8'h3c
`define NPC_OFF_PMCAP       8'h40
`define NPC_OFF_PMCTL       8'h44
`define NPC_OFF_MSICAP      8'h48
`define NPC_OFF_MSIADDR     8'h4c
`define NPC_OFF_MSIUPPER    8'h50
`define NPC_OFF_MSIDATA     8'h54
`define NPC_OFF_EXPCAP      8'h68

// capability chain
`define NPC_CAP_PM_PTR      8'h40
`define NPC_CAP_MSI_PTR     8'h48
`define NPC_CAP_EXP_PTR     8'h68
`define NPC_CAP_NEXT_PTR    8'ha4
`define NPC_CAP_ID_PM       8'h01
`define NPC_CAP_ID_MSI      8'h05
`define NPC_CAP_ID_EXP      8'h10
`define NPC_PM_REV          3'h3
`define NPC_PME_SUPPORT     5'h19
`define NPC_EXP_VERSION     4'h2
`define NPC_EXP_PORT_TYPE   4'h0

// interrupt pin
`define NPC_IRQ_PIN_INTA    8'h01

// memory-type encodings
`define NPC_MT_32           2'h0
`define NPC_MT_64           2'h2

// power states
`define NPC_PS_D0           2'h0
`define NPC_PS_D3HOT        2'h3

// field positions and widths
`define NPC_BAR_BASE_LSB    20
`define NPC_BAR_BASE_W      12
`define NPC_BAR_TYPE_LSB    1
`define NPC_UPPER_LSB       4
`define NPC_PM_PME_EN_BIT   8
`define NPC_PM_NOSOFT_BIT   3
`define NPC_MSI_EN_BIT      16
`define NPC_MSI_MME_LSB     20
`define NPC_MSI_64_BIT      23
`define NPC_ADDR_LSB        2
`define NPC_PM_PSTATE_LSB   0
`define NPC_IRQ_LINE_LSB    0
`define NPC_MDATA_LSB       0

// hot reset pulse length in cycles, and counter value on its last cycle
`define NPC_HOT_RST_CYCLES  4'h8
`define NPC_HOT_RST_LAST    4'h1

`endif

// ===== npc_pkg.sv
package npc_pkg;
	typedef logic [7:0]  npc_addr_t;
	typedef logic [31:0] npc_word_t;
	typedef logic [3:0]  npc_be_t;
	typedef enum logic [1:0]
	{
		NPC_HR_IDLE  = 2'b00,
		NPC_HR_PULSE = 2'b01
	} npc_hr_state_t;
endpackage

// ===== npc_port_config_header.sv
`include "npc_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module npc_port_config_header
(
	input  wire logic              ref_clk,
	input  wire logic              rst,
	input  wire logic              cfg_wr,
	input  wire logic              cfg_rd,
	input  wire npc_pkg::npc_addr_t cfg_addr,
	input  wire npc_pkg::npc_be_t   cfg_be,
	input  wire npc_pkg::npc_word_t cfg_wdata,
	output var  npc_pkg::npc_word_t cfg_rdata,
	output logic                   cfg_ack,
	input  wire logic              win2_type_64,
	input  wire logic              win4_type_64,
	input  wire logic              no_soft_reset_strap,
	input  wire logic [15:0]       board_maker_code,
	input  wire logic [15:0]       board_product_code,
	input  wire logic              irq_event,
	input  wire logic              pme_event,
	output logic                   intx_assert,
	output logic                   msi_req,
	output var  npc_pkg::npc_word_t msi_addr_low,
	output var  npc_pkg::npc_word_t msi_addr_high,
	output var  logic [15:0]       msi_data,
	output logic                   pme_msg_req,
	output logic                   hot_reset,
	output logic                   internal_reset,
	output logic                   downstream_reset_out_n,
	output logic [1:0]             power_state
);
	import npc_pkg::*;

	logic [11:0]   win2_base_reg;
	logic [31:0]   win3_reg;
	logic [11:0]   win4_base_reg;
	logic [31:0]   win5_reg;
	logic [7:0]    irq_line_reg;
	logic [1:0]    pstate_reg;
	logic          pme_en_reg;
	logic          no_soft_reg;
	logic          msi_en_reg;
	logic [2:0]    mme_reg;
	logic [29:0]   maddr_reg;
	logic [31:0]   mupper_reg;
	logic [15:0]   mdata_reg;
	npc_word_t     rdata_reg;
	logic          ack_reg;
	npc_hr_state_t hr_state_reg;
	logic [3:0]    hr_cnt_reg;
	logic          hr_internal_reg;
	logic          strap_taken_reg;

	// byte-lane write mask
	wire npc_word_t wmask = {{8{cfg_be[3]}}, {8{cfg_be[2]}}, {8{cfg_be[1]}}, {8{cfg_be[0]}}};
	wire npc_word_t wval  = cfg_wdata & wmask;
	wire            cfg_req = cfg_rd || cfg_wr;

	// write-data fields
	wire [11:0] wr_base    = wval[`NPC_BAR_BASE_LSB +: `NPC_BAR_BASE_W];
	wire [11:0] keep_base  = ~wmask[`NPC_BAR_BASE_LSB +: `NPC_BAR_BASE_W];
	wire [1:0]  wr_pstate  = cfg_wdata[`NPC_PM_PSTATE_LSB +: 2];
	wire        wr_pme_en  = cfg_wdata[`NPC_PM_PME_EN_BIT];
	wire [7:0]  wr_irq_ln  = cfg_wdata[`NPC_IRQ_LINE_LSB +: 8];
	wire        wr_msi_en  = cfg_wdata[`NPC_MSI_EN_BIT];
	wire [2:0]  wr_mme     = cfg_wdata[`NPC_MSI_MME_LSB +: 3];
	wire [29:0] wr_maddr   = wval[`NPC_ADDR_LSB +: 30];
	wire [29:0] keep_maddr = ~wmask[`NPC_ADDR_LSB +: 30];
	wire [15:0] wr_mdata   = wval[`NPC_MDATA_LSB +: 16];
	wire [15:0] keep_mdata = ~wmask[`NPC_MDATA_LSB +: 16];

	wire hit_win2   = cfg_wr && (cfg_addr == `NPC_OFF_WIN2);
	wire hit_win3   = cfg_wr && (cfg_addr == `NPC_OFF_WIN3);
	wire hit_win4   = cfg_wr && (cfg_addr == `NPC_OFF_WIN4);
	wire hit_win5   = cfg_wr && (cfg_addr == `NPC_OFF_WIN5);
	wire hit_irq    = cfg_wr && (cfg_addr == `NPC_OFF_IRQ);
	wire hit_pmctl  = cfg_wr && (cfg_addr == `NPC_OFF_PMCTL);
	wire hit_msicap = cfg_wr && (cfg_addr == `NPC_OFF_MSICAP);
	wire hit_maddr  = cfg_wr && (cfg_addr == `NPC_OFF_MSIADDR);
	wire hit_mupper = cfg_wr && (cfg_addr == `NPC_OFF_MSIUPPER);
	wire hit_mdata  = cfg_wr && (cfg_addr == `NPC_OFF_MSIDATA);

	// memory-type fields of the lower windows
	wire [1:0] win2_type = win2_type_64 ? `NPC_MT_64 : `NPC_MT_32;
	wire [1:0] win4_type = win4_type_64 ? `NPC_MT_64 : `NPC_MT_32;

	// merged write values, untouched lanes keep old content
	wire [11:0] win2_new = wr_base | (win2_base_reg & keep_base);
	wire [11:0] win4_new = wr_base | (win4_base_reg & keep_base);
	wire [31:0] win3_new = (wval | (win3_reg & ~wmask));
	wire [31:0] win5_new = (wval | (win5_reg & ~wmask));

	wire [31:0] win3_wmask = win2_type_64 ? 32'hffffffff : 32'hfffffff0;
	wire [31:0] win5_wmask = win4_type_64 ? 32'hffffffff : 32'h00000000;

	// power state write and D3hot to D0 detection
	wire [1:0] pstate_new  = cfg_be[0] ? wr_pstate : pstate_reg;
	wire       d3_to_d0    = hit_pmctl && cfg_be[0] && (pstate_reg == `NPC_PS_D3HOT)
	                         && (pstate_new == `NPC_PS_D0);

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			win2_base_reg <= 12'h000;
			win3_reg      <= 32'h00000000;
			win4_base_reg <= 12'h000;
			win5_reg      <= 32'h00000000;
		end
		else
		begin
			if (hit_win2)
				win2_base_reg <= win2_new;
			if (hit_win3)
				win3_reg <= win3_new & win3_wmask;
			else if (!win2_type_64)
				win3_reg[3:0] <= 4'h0;
			if (hit_win4)
				win4_base_reg <= win4_new;
			if (hit_win5)
				win5_reg <= win5_new & win5_wmask;
			else if (!win4_type_64)
				win5_reg <= 32'h00000000;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			irq_line_reg <= 8'h00;
			pstate_reg   <= `NPC_PS_D0;
			pme_en_reg   <= 1'b0;
		end
		else
		begin
			if (hit_irq && cfg_be[0])
				irq_line_reg <= wr_irq_ln;
			if (hit_pmctl && cfg_be[0])
				pstate_reg <= pstate_new;
			if (hit_pmctl && cfg_be[1])
				pme_en_reg <= wr_pme_en;
		end
	end

	// strap caught on the first clocked cycle after reset
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			strap_taken_reg <= 1'b0;
		else
			strap_taken_reg <= 1'b1;
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			no_soft_reg <= 1'b1;
		else if (!strap_taken_reg)
			no_soft_reg <= no_soft_reset_strap;
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			msi_en_reg <= 1'b0;
			mme_reg    <= 3'h0;
			maddr_reg  <= 30'h00000000;
			mupper_reg <= 32'h00000000;
			mdata_reg  <= 16'h0000;
		end
		else
		begin
			if (hit_msicap && cfg_be[2])
			begin
				msi_en_reg <= wr_msi_en;
				mme_reg    <= wr_mme;
			end
			if (hit_maddr)
				maddr_reg <= wr_maddr | (maddr_reg & keep_maddr);
			if (hit_mupper)
				mupper_reg <= wval | (mupper_reg & ~wmask);
			if (hit_mdata)
				mdata_reg <= wr_mdata | (mdata_reg & keep_mdata);
		end
	end

	// last cycle of the hot reset pulse
	wire hr_last = (hr_cnt_reg == `NPC_HOT_RST_LAST);

	// hot reset pulse after a D3hot to D0 write
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			hr_state_reg    <= NPC_HR_IDLE;
			hr_cnt_reg      <= 4'h0;
			hr_internal_reg <= 1'b0;
		end
		else
		begin
			unique case (hr_state_reg)
				NPC_HR_IDLE:
				begin
					if (d3_to_d0)
					begin
						hr_state_reg    <= NPC_HR_PULSE;
						hr_cnt_reg      <= `NPC_HOT_RST_CYCLES;
						hr_internal_reg <= !no_soft_reg;
					end
				end
				NPC_HR_PULSE:
				begin
					hr_cnt_reg <= hr_cnt_reg - 4'h1;
					if (hr_last)
					begin
						hr_state_reg    <= NPC_HR_IDLE;
						hr_internal_reg <= 1'b0;
					end
				end
				default:
					hr_state_reg <= NPC_HR_IDLE;
			endcase
		end
	end

	wire hr_active = (hr_state_reg == NPC_HR_PULSE);

	// fixed fields of the window words
	wire [15:0] win_rsvd   = 16'h0000;
	wire        win_pref   = 1'b0;
	wire        win_mem    = 1'b0;

	// fixed fields of the power capability
	wire [4:0]  pm_pme_sup = `NPC_PME_SUPPORT;
	wire [1:0]  pm_d2_d1   = 2'b00;
	wire [2:0]  pm_aux_cur = 3'h0;
	wire        pm_dsi     = 1'b0;
	wire [1:0]  pm_rsvd    = 2'b00;
	wire [2:0]  pm_rev     = `NPC_PM_REV;

	// fixed fields of the power control word
	wire [15:0] pm_ext     = 16'h0000;
	wire        pm_status  = 1'b0;
	wire [1:0]  pm_scale   = 2'b00;
	wire [3:0]  pm_dsel    = 4'h0;
	wire [3:0]  pm_rsvd_hi = 4'h0;
	wire        pm_rsvd_lo = 1'b0;

	// fixed fields of the message interrupt capability
	wire [7:0]  msi_rsvd   = 8'h00;
	wire        msi_cap64  = 1'b1;
	wire [2:0]  msi_mmc    = 3'h0;

	// read mux
	wire [31:0] win2_rd = {win2_base_reg, win_rsvd, win_pref, win2_type, win_mem};
	wire [31:0] win3_rd = win3_reg;
	wire [31:0] win4_rd = {win4_base_reg, win_rsvd, win_pref, win4_type, win_mem};
	wire [31:0] win5_rd = win5_reg;
	wire [31:0] pmcap_rd = {pm_pme_sup, pm_d2_d1, pm_aux_cur, pm_dsi, pm_rsvd, pm_rev,
	                        `NPC_CAP_MSI_PTR, `NPC_CAP_ID_PM};
	wire [31:0] pmctl_rd = {pm_ext, pm_status, pm_scale, pm_dsel, pme_en_reg, pm_rsvd_hi, no_soft_reg,
	                        pm_rsvd_lo, pstate_reg};
	wire [31:0] msicap_rd = {msi_rsvd, msi_cap64, mme_reg, msi_mmc, msi_en_reg,
	                         `NPC_CAP_EXP_PTR, `NPC_CAP_ID_MSI};
	wire [31:0] expcap_rd = {8'h00, `NPC_EXP_PORT_TYPE, `NPC_EXP_VERSION,
	                         `NPC_CAP_NEXT_PTR, `NPC_CAP_ID_EXP};

	npc_word_t rd_mux;
	always_comb
	begin
		unique case (cfg_addr)
			`NPC_OFF_WIN2:     rd_mux = win2_rd;
			`NPC_OFF_WIN3:     rd_mux = win3_rd;
			`NPC_OFF_WIN4:     rd_mux = win4_rd;
			`NPC_OFF_WIN5:     rd_mux = win5_rd;
			`NPC_OFF_SUBSYS:   rd_mux = {board_product_code, board_maker_code};
			`NPC_OFF_CAPPTR:   rd_mux = {24'h000000, `NPC_CAP_PM_PTR};
			`NPC_OFF_IRQ:      rd_mux = {16'h0000, `NPC_IRQ_PIN_INTA, irq_line_reg};
			`NPC_OFF_PMCAP:    rd_mux = pmcap_rd;
			`NPC_OFF_PMCTL:    rd_mux = pmctl_rd;
			`NPC_OFF_MSICAP:   rd_mux = msicap_rd;
			`NPC_OFF_MSIADDR:  rd_mux = {maddr_reg, 2'b00};
			`NPC_OFF_MSIUPPER: rd_mux = mupper_reg;
			`NPC_OFF_MSIDATA:  rd_mux = {16'h0000, mdata_reg};
			`NPC_OFF_EXPCAP:   rd_mux = expcap_rd;
			default:           rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			rdata_reg <= 32'h00000000;
			ack_reg   <= 1'b0;
		end
		else
		begin
			ack_reg <= cfg_req;
			if (cfg_rd)
				rdata_reg <= rd_mux;
		end
	end

	// interrupt delivery path selection
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			intx_assert <= 1'b0;
			msi_req     <= 1'b0;
			pme_msg_req <= 1'b0;
		end
		else
		begin
			intx_assert <= irq_event && !msi_en_reg;
			msi_req     <= irq_event && msi_en_reg;
			pme_msg_req <= pme_event && pme_en_reg;
		end
	end

	assign cfg_rdata              = rdata_reg;
	assign cfg_ack                = ack_reg;
	assign msi_addr_low           = {maddr_reg, 2'b00};
	assign msi_addr_high          = mupper_reg;
	assign msi_data               = mdata_reg;
	assign hot_reset              = hr_active;
	assign internal_reset         = hr_internal_reg;
	assign downstream_reset_out_n = 1'b1;
	assign power_state            = pstate_reg;

endmodule // npc_port_config_header

`default_nettype wire

// ===== npc_cfg_checker_properties.sv
`timescale 1ns/100ps
`default_nettype none
module npc_cfg_checker
(
	input wire logic               ref_clk,
	input wire logic               rst,
	input wire logic               cfg_wr,
	input wire logic               cfg_rd,
	input wire npc_pkg::npc_addr_t cfg_addr,
	input wire npc_pkg::npc_be_t   cfg_be,
	input wire npc_pkg::npc_word_t cfg_wdata,
	input wire npc_pkg::npc_word_t cfg_rdata,
	input wire logic               irq_event,
	input wire logic               pme_event,
	input wire logic               intx_assert,
	input wire logic               msi_req,
	input wire npc_pkg::npc_word_t msi_addr_low,
	input wire logic               pme_msg_req,
	input wire logic               hot_reset,
	input wire logic               internal_reset,
	input wire logic               downstream_reset_out_n,
	input wire logic [1:0]         power_state
);
	import npc_pkg::*;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	wire logic       pm_wr = cfg_wr && cfg_addr == 8'h44 && cfg_be[0];
	wire logic [1:0] wr_ps = cfg_wdata[1:0];
	a_dsrst_high: assert property (downstream_reset_out_n)
		else $error("downstream reset asserted");
	a_hot_pulse: assert property (pm_wr && power_state == 2'h3 && wr_ps == 2'h0 && !hot_reset
		|=> hot_reset [*8] ##1 !hot_reset) else $error("hot reset pulse wrong");
	a_int_in_hot: assert property (internal_reset |-> hot_reset)
		else $error("internal reset outside hot reset");
	a_ps_written: assert property (pm_wr && !hot_reset |=> power_state == $past(wr_ps))
		else $error("power state not written");
	a_irq_route: assert property (irq_event |=> intx_assert ^ msi_req)
		else $error("interrupt not routed once");
	a_irq_cause: assert property (!$past(irq_event) |-> !intx_assert && !msi_req)
		else $error("interrupt without cause");
	a_pme_cause: assert property (pme_msg_req |-> $past(pme_event))
		else $error("pme message without event");
	a_addr_align: assert property (msi_addr_low[1:0] == 2'h0)
		else $error("message address not aligned");
	a_pmcap_read: assert property (cfg_rd && cfg_addr == 8'h40 |=> cfg_rdata == 32'hc8034801)
		else $error("power capability wrong");
	a_cap_start: assert property (cfg_rd && cfg_addr == 8'h34 |=> cfg_rdata == 32'h00000040)
		else $error("capability pointer wrong");
	c_hot: cover property (hot_reset && internal_reset);
	c_msi: cover property (msi_req);
	c_pme: cover property (pme_msg_req);
endmodule // npc_cfg_checker
bind npc_port_config_header npc_cfg_checker chk_i (.ref_clk, .rst, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be,
	.cfg_wdata, .cfg_rdata, .irq_event, .pme_event, .intx_assert, .msi_req, .msi_addr_low, .pme_msg_req,
	.hot_reset, .internal_reset, .downstream_reset_out_n, .power_state);
`default_nettype wire

// ===== npc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module npc_host_model
(
	input  wire logic               ref_clk,
	input  wire logic               cfg_ack,
	input  wire npc_pkg::npc_word_t cfg_rdata,
	output var  logic               cfg_wr,
	output var  logic               cfg_rd,
	output var  npc_pkg::npc_addr_t cfg_addr,
	output var  npc_pkg::npc_be_t   cfg_be,
	output var  npc_pkg::npc_word_t cfg_wdata
);
	import npc_pkg::*;
	initial
	begin
		cfg_wr = 1'b0;
		cfg_rd = 1'b0;
		cfg_addr = 8'h00;
		cfg_be = 4'h0;
		cfg_wdata = 32'h0;
	end
	// one access from a falling edge; released address and data lines show inverted values, byte enables hold
	task automatic acc(input logic w, input npc_addr_t a, input npc_be_t b, input npc_word_t d,
		output npc_word_t q);
		cfg_wr = w;
		cfg_rd = !w;
		cfg_addr = a;
		cfg_be = b;
		cfg_wdata = d;
		@(negedge ref_clk);
		q = (cfg_ack === 1'b1) ? cfg_rdata : 'x;
		cfg_wr = 1'b0;
		cfg_rd = 1'b0;
		cfg_addr = ~a;
		cfg_wdata = ~d;
		@(negedge ref_clk);
	endtask
endmodule // npc_host_model
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import npc_pkg::*;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic cfg_wr, cfg_rd, cfg_ack, intx_assert, msi_req, pme_msg_req, hot_reset, internal_reset;
	logic downstream_reset_out_n;
	logic win2_type_64 = 1'b0;
	logic win4_type_64 = 1'b0;
	logic no_soft_reset_strap = 1'b1;
	logic irq_event = 1'b0;
	logic pme_event = 1'b0;
	logic [1:0] power_state;
	logic [15:0] msi_data;
	npc_addr_t cfg_addr;
	npc_be_t cfg_be;
	npc_word_t cfg_wdata, cfg_rdata, msi_addr_low, msi_addr_high, q;
	int miscompares = 0;
	int comparisons = 0;
	npc_addr_t at [15] = '{8'h18, 8'h1c, 8'h20, 8'h24, 8'h2c, 8'h34, 8'h3c, 8'h40, 8'h44, 8'h48,
		8'h4c, 8'h50, 8'h54, 8'h68, 8'h00};
	npc_word_t ex [15] = '{0, 0, 0, 0, 32'h5a5a1a2b, 32'h40, 32'h100, 32'hc8034801, 32'h8, 32'h806805,
		0, 0, 0, 32'h2a410, 0};
	always #20 ref_clk = ~ref_clk;
	npc_host_model host (.ref_clk, .cfg_ack, .cfg_rdata, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata);
	// board codes are arbitrary values
	npc_port_config_header DUT (.ref_clk, .rst, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata,
		.cfg_ack, .win2_type_64, .win4_type_64, .no_soft_reset_strap, .board_maker_code(16'h1a2b),
		.board_product_code(16'h5a5a), .irq_event, .pme_event, .intx_assert, .msi_req, .msi_addr_low,
		.msi_addr_high, .msi_data, .pme_msg_req, .hot_reset, .internal_reset, .downstream_reset_out_n,
		.power_state);
	task chk(input string n, input npc_word_t s, input npc_word_t e);
		comparisons++;
		if (s !== e)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task rd(input npc_addr_t a, input npc_word_t e);
		host.acc(1'b0, a, 4'hf, 32'h0, q);
		chk($sformatf("read %h", a), q, e);
	endtask
	task wr(input npc_addr_t a, input npc_be_t b, input npc_word_t d);
		host.acc(1'b1, a, b, d, q);
	endtask
	task t_defaults;
		for (int i = 0; i < 15; i++)
			rd(at[i], ex[i]);
	endtask
	// type pins set before upper bits, then size with all ones
	task t_windows(input logic m);
		win2_type_64 = m;
		win4_type_64 = m;
		@(negedge ref_clk);
		for (int i = 0; i < 4; i++)
			wr(npc_addr_t'(8'h18 + 4 * i), 4'hf, 32'hffffffff);
		rd(8'h18, m ? 32'hfff00004 : 32'hfff00000);
		rd(8'h1c, m ? 32'hffffffff : 32'hfffffff0);
		rd(8'h20, m ? 32'hfff00004 : 32'hfff00000);
		rd(8'h24, m ? 32'hffffffff : 32'h0);
	endtask
	task t_fields;
		for (int i = 6; i < 13; i++)
			wr(at[i], 4'hf, 32'hffffffff);
		rd(8'h3c, 32'h1ff);
		rd(8'h40, 32'hc8034801);
		rd(8'h44, 32'h10b);
		wr(8'h44, 4'h2, 32'h0);
		rd(8'h44, 32'hb);
		rd(8'h48, 32'hf16805);
		rd(8'h4c, 32'hfffffffc);
		rd(8'h50, 32'hffffffff);
		rd(8'h54, 32'hffff);
		chk("message address", msi_addr_low, 32'hfffffffc);
		chk("message upper", msi_addr_high, 32'hffffffff);
		chk("message data", 32'(msi_data), 32'hffff);
	endtask
	task t_events;
		irq_event = 1'b1;
		@(negedge ref_clk);
		irq_event = 1'b0;
		chk("msi and intx", 32'({msi_req, intx_assert}), 32'h2);
		pme_event = 1'b1;
		@(negedge ref_clk);
		pme_event = 1'b0;
		chk("pme off", 32'(pme_msg_req), 32'h0);
		wr(8'h44, 4'h2, 32'h100);
		pme_event = 1'b1;
		@(negedge ref_clk);
		pme_event = 1'b0;
		chk("pme on", 32'(pme_msg_req), 32'h1);
		wr(8'h48, 4'h4, 32'h0);
		irq_event = 1'b1;
		@(negedge ref_clk);
		irq_event = 1'b0;
		chk("intx only", 32'({msi_req, intx_assert}), 32'h1);
	endtask
	task t_hot(input logic s);
		int nh;
		int ni;
		nh = 0;
		ni = 0;
		no_soft_reset_strap = s;
		rst = 1'b1;
		repeat (8) @(negedge ref_clk);
		rst = 1'b0;
		@(negedge ref_clk);
		rd(8'h44, {28'h0, s, 3'h0});
		wr(8'h44, 4'h1, 32'h3);
		fork
			wr(8'h44, 4'h1, 32'h0);
			repeat (13)
			begin
				@(negedge ref_clk);
				nh += (hot_reset === 1'b1);
				ni += (internal_reset === 1'b1);
				chk("downstream reset", 32'(downstream_reset_out_n), 32'h1);
			end
		join
		chk("hot reset cycles", 32'(nh), 32'h8);
		chk("internal reset cycles", 32'(ni), s ? 32'h0 : 32'h8);
		chk("power state", 32'(power_state), 32'h0);
	endtask
	task report_and_stop;
		$display("miscompares %0d comparisons %0d", miscompares, comparisons);
		if (miscompares == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (8) @(negedge ref_clk);
		rst = 1'b0;
		@(negedge ref_clk);
		t_defaults();
		t_windows(1'b0);
		t_windows(1'b1);
		t_fields();
		t_events();
		t_hot(1'b1);
		t_hot(1'b0);
		report_and_stop();
	end
	initial
	begin
		repeat (5000) @(posedge ref_clk);
		miscompares++;
		report_and_stop();
	end
endmodule // tb_top
`default_nettype wire
